// ===== hw/sensor_consts.svh
// Notes on behaviour
// - Device captures the instruction bit on sclk rise.
// - Device changes its output bit on sclk rise.
// - Host samples output, changes input on sclk fall.
// - Host alone makes sclk; transfers start with it.
// - Output carries result, calibration word or busy.
// - Seven instructions: two conversions, four words, reset.
// - Three high bits open every instruction except reset.
// - Three low bits close every instruction.
// - Four-bit setup field picks what is read.
// - Conversion start acknowledged by output rising.
// - Host gives two clocks after the acknowledge.
// - Host holds sclk low; output falls at end.
// - Seventeen clocks read out the sixteen-bit result.
// - Readout may pause and resume at same bit.
// - Host reads result before the next conversion.
// - Reset pattern returns device to idle from anywhere.
// - Reset pattern is twenty-one bits on the input.
// - Host ignores output while sending reset pattern.
// - Host may send reset before each conversion.
// - Host may use the end-of-conversion edge as event.
// - Sixty-four-bit calibration store read as four words.
// - Results and calibration words are sixteen bits.
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH
`define WORD_W 16
`define CALIB_W 64
`define CNT_W 5
`define START_LEN 2'h3
`define SETUP_LEN 4
`define SETUP_LAST 5'h03
`define STOP_LAST 5'h02
`define ACK_LAST 5'h01
`define READ_LAST 5'h10
`define FRAME_BITS 5'h0A
`define EXTRA_CLKS 5'h02
`define READ_CLKS 5'h11
`define RESET_LEN 21
`define RESET_BITS 5'h15
`define RESET_PATTERN 21'h155540
`define CODE_PRESSURE 4'hA
`define CODE_TEMPERATURE 4'h9
`define CODE_CALIB_FIRST 4'h5
`define CODE_CALIB_SECOND 4'h6
`define CODE_CALIB_THIRD 4'hC
`define CODE_CALIB_FOURTH 4'h3
`define CALIB_DEFAULT 64'h0123456789ABCDEF
`define HALF_W 8
`define SCLK_HALF 8'h04
`endif

// ===== hw/sensor_pkg.sv
package sensor_pkg;
	typedef enum logic [4:0] {
		link_idle = 5'h01,
		link_setup = 5'h02,
		link_stop = 5'h04,
		link_ack = 5'h08,
		link_read = 5'h10
	} link_state_e;
	typedef enum logic [5:0] {
		host_idle = 6'h01,
		host_send = 6'h02,
		host_extra = 6'h04,
		host_wait = 6'h08,
		host_read = 6'h10,
		host_spare = 6'h20
	} host_state_e;
	typedef enum logic [2:0] {
		cmd_pressure = 3'h0,
		cmd_temperature = 3'h1,
		cmd_calib_first = 3'h2,
		cmd_calib_second = 3'h3,
		cmd_calib_third = 3'h4,
		cmd_calib_fourth = 3'h5,
		cmd_reset = 3'h6
	} cmd_e;
endpackage

// ===== hw/sensor_link_if.sv
`timescale 1ns/10ps
interface sensor_link_if;
	logic sclk;
	logic din;
	logic dout;
	modport dev (
		input sclk,
		input din,
		output dout
	);
	modport host (
		output sclk,
		output din,
		input dout
	);
endinterface

// ===== hw/sensor_port_host.sv
`timescale 1ns/10ps
`include "sensor_consts.svh"
module sensor_port_host
	import sensor_pkg::*;
#(
	parameter logic [`HALF_W-1:0] SCLK_HALF = `SCLK_HALF,
	parameter logic [`SETUP_LEN-1:0] CODE_PRESSURE = `CODE_PRESSURE,
	parameter logic [`SETUP_LEN-1:0] CODE_TEMPERATURE = `CODE_TEMPERATURE,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_FIRST = `CODE_CALIB_FIRST,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_SECOND = `CODE_CALIB_SECOND,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_THIRD = `CODE_CALIB_THIRD,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_FOURTH = `CODE_CALIB_FOURTH,
	parameter logic [`RESET_LEN-1:0] RESET_PATTERN = `RESET_PATTERN
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Link to the sensor
	sensor_link_if.host link,
	// Command side
	input wire logic cmd_valid,
	input wire cmd_e cmd_op,
	output logic cmd_ready,
	// Answer side
	output logic rsp_valid,
	output logic [`WORD_W-1:0] rsp_data
);
	host_state_e state;
	logic dout_meta;
	logic dout_s;
	logic [`HALF_W-1:0] div;
	logic sclk_q;
	logic din_q;
	logic run;
	logic fall;
	logic [`RESET_LEN-1:0] frame;
	logic [`RESET_LEN-1:0] next_frame;
	logic [`SETUP_LEN-1:0] code;
	logic [`CNT_W-1:0] left;
	logic is_conv;
	logic is_reset;

	assign link.sclk = sclk_q;
	assign link.din = din_q;
	assign fall = run && (div == '0) && sclk_q;

	always_ff @(posedge core_clk) begin
		dout_meta <= link.dout;
		dout_s <= dout_meta;
	end

	always_comb begin
		unique case (cmd_op)
			cmd_pressure: code = CODE_PRESSURE;
			cmd_temperature: code = CODE_TEMPERATURE;
			cmd_calib_first: code = CODE_CALIB_FIRST;
			cmd_calib_second: code = CODE_CALIB_SECOND;
			cmd_calib_third: code = CODE_CALIB_THIRD;
			default: code = CODE_CALIB_FOURTH;
		endcase
		if (cmd_op == cmd_reset) begin
			next_frame = RESET_PATTERN;
		end else begin
			next_frame = {3'h7, code, 3'h0, 11'h000};
		end
	end

	// Divider; sclk also runs in reset so the sensor end can reset
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			// Else branch also catches the unknown start value
			if (div == 8'h01) begin
				div <= 8'h02;
			end else begin
				div <= 8'h01;
			end
			sclk_q <= div[1];
		end else if (!run) begin
			div <= SCLK_HALF - 8'h01;
			sclk_q <= 1'b0;
		end else if (div == '0) begin
			div <= SCLK_HALF - 8'h01;
			sclk_q <= ~sclk_q;
		end else begin
			div <= div - 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		rsp_valid <= 1'b0;
		if (!rst_b) begin
			state <= host_idle;
			run <= 1'b0;
			din_q <= 1'b0;
			cmd_ready <= 1'b0;
			frame <= '0;
			left <= '0;
			is_conv <= 1'b0;
			is_reset <= 1'b0;
			rsp_data <= '0;
		end else begin
			unique case (state)
				host_idle: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						din_q <= next_frame[`RESET_LEN-1];
						frame <= {next_frame[`RESET_LEN-2:0], 1'b0};
						is_reset <= (cmd_op == cmd_reset);
						is_conv <= (cmd_op == cmd_pressure) ||
							(cmd_op == cmd_temperature);
						left <= (cmd_op == cmd_reset) ? `RESET_BITS :
							`FRAME_BITS;
						run <= 1'b1;
						state <= host_send;
					end
				end
				host_send: if (fall) begin
					if (left == 5'h01) begin
						din_q <= 1'b0;
						if (is_reset) begin
							run <= 1'b0;
							state <= host_idle;
						end else if (is_conv && dout_s) begin
							left <= `EXTRA_CLKS;
							state <= host_extra;
						end else if (is_conv) begin
							run <= 1'b0;
							state <= host_idle;
						end else begin
							left <= `READ_CLKS;
							state <= host_read;
						end
					end else begin
						din_q <= frame[`RESET_LEN-1];
						frame <= {frame[`RESET_LEN-2:0], 1'b0};
						left <= left - 5'h01;
					end
				end
				host_extra: if (fall) begin
					if (left == 5'h01) begin
						run <= 1'b0;
						state <= host_wait;
					end else begin
						left <= left - 5'h01;
					end
				end
				host_wait: if (!dout_s) begin
					run <= 1'b1;
					left <= `READ_CLKS;
					state <= host_read;
				end
				host_read: if (fall) begin
					if (left == 5'h01) begin
						run <= 1'b0;
						rsp_valid <= 1'b1;
						state <= host_idle;
					end else begin
						rsp_data <= {rsp_data[`WORD_W-2:0], dout_s};
						left <= left - 5'h01;
					end
				end
				default: state <= host_idle;
			endcase
		end
	end
endmodule

// ===== hw/sensor_port_dev.sv
`timescale 1ns/10ps
`include "sensor_consts.svh"
module sensor_port_dev
	import sensor_pkg::*;
#(
	parameter logic [`SETUP_LEN-1:0] CODE_PRESSURE = `CODE_PRESSURE,
	parameter logic [`SETUP_LEN-1:0] CODE_TEMPERATURE = `CODE_TEMPERATURE,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_FIRST = `CODE_CALIB_FIRST,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_SECOND = `CODE_CALIB_SECOND,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_THIRD = `CODE_CALIB_THIRD,
	parameter logic [`SETUP_LEN-1:0] CODE_CALIB_FOURTH = `CODE_CALIB_FOURTH,
	parameter logic [`RESET_LEN-1:0] RESET_PATTERN = `RESET_PATTERN,
	parameter logic [`CALIB_W-1:0] CALIB_STORE = `CALIB_DEFAULT
)(
	// Converter clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Link to the host
	sensor_link_if.dev link,
	// Converter side
	output logic adc_start,
	output logic adc_kind,
	output logic adc_abort,
	input wire logic adc_done,
	input wire logic [`WORD_W-1:0] adc_value
);
	// Link domain
	link_state_e state;
	logic link_rst_meta;
	logic link_rst_b;
	logic [`RESET_LEN-1:0] hist;
	logic [`RESET_LEN-1:0] next_hist;
	logic reset_seen;
	logic [1:0] ones;
	logic [`SETUP_LEN-1:0] setup;
	logic [`CNT_W-1:0] cnt;
	logic code_conv;
	logic code_calib;
	logic stop_last;
	logic read_conv;
	logic [1:0] word_sel;
	logic [1:0] next_word_sel;
	logic [`WORD_W-1:0] calib_word;
	logic [`WORD_W-1:0] rd_word;
	logic [`WORD_W-1:0] shreg;
	logic dout_link;
	logic req_tgl;
	logic kind_link;
	logic abort_tgl;
	// Converter domain
	logic [2:0] req_sync;
	logic [1:0] kind_sync;
	logic [2:0] abort_sync;
	logic req_edge;
	logic abort_edge;
	logic busy;
	logic [`WORD_W-1:0] result;

	// Busy keeps the line high while sclk stands still
	assign link.dout = dout_link | busy;

	always_ff @(posedge link.sclk) begin
		link_rst_meta <= rst_b;
		link_rst_b <= link_rst_meta;
	end

	assign next_hist = {hist[`RESET_LEN-2:0], link.din};
	assign reset_seen = (next_hist == RESET_PATTERN);

	always_ff @(posedge link.sclk) begin
		if (!link_rst_b) begin
			hist <= '0;
		end else begin
			hist <= next_hist;
		end
	end

	always_comb begin
		code_conv = 1'b0;
		code_calib = 1'b1;
		next_word_sel = 2'h0;
		unique case (setup)
			CODE_PRESSURE, CODE_TEMPERATURE: begin
				code_conv = 1'b1;
				code_calib = 1'b0;
			end
			CODE_CALIB_FIRST: next_word_sel = 2'h0;
			CODE_CALIB_SECOND: next_word_sel = 2'h1;
			CODE_CALIB_THIRD: next_word_sel = 2'h2;
			CODE_CALIB_FOURTH: next_word_sel = 2'h3;
			default: code_calib = 1'b0;
		endcase
	end

	assign stop_last = (state == link_stop) && (cnt == `STOP_LAST) &&
		!link.din;

	always_comb begin
		unique case (word_sel)
			2'h0: calib_word = CALIB_STORE[63:48];
			2'h1: calib_word = CALIB_STORE[47:32];
			2'h2: calib_word = CALIB_STORE[31:16];
			default: calib_word = CALIB_STORE[15:0];
		endcase
	end

	// Result is quiet by the time readout clocks arrive
	assign rd_word = read_conv ? result : calib_word;

	always_ff @(posedge link.sclk) begin
		if (!link_rst_b || reset_seen) begin
			state <= link_idle;
			cnt <= '0;
			ones <= '0;
			setup <= '0;
			read_conv <= 1'b0;
			word_sel <= 2'h0;
		end else begin
			unique case (state)
				link_idle: begin
					if (!link.din) begin
						ones <= '0;
					end else if (ones == `START_LEN - 2'h1) begin
						ones <= '0;
						cnt <= '0;
						state <= link_setup;
					end else begin
						ones <= ones + 2'h1;
					end
				end
				link_setup: begin
					setup <= {setup[`SETUP_LEN-2:0], link.din};
					if (cnt == `SETUP_LAST) begin
						cnt <= '0;
						state <= link_stop;
					end else begin
						cnt <= cnt + 5'h01;
					end
				end
				link_stop: begin
					if (link.din) begin
						state <= link_idle;
					end else if (cnt == `STOP_LAST) begin
						cnt <= '0;
						read_conv <= code_conv;
						word_sel <= next_word_sel;
						if (code_conv) begin
							state <= link_ack;
						end else if (code_calib) begin
							state <= link_read;
						end else begin
							state <= link_idle;
						end
					end else begin
						cnt <= cnt + 5'h01;
					end
				end
				link_ack: begin
					if (cnt == `ACK_LAST) begin
						cnt <= '0;
						state <= link_read;
					end else begin
						cnt <= cnt + 5'h01;
					end
				end
				link_read: begin
					if (cnt == `READ_LAST) begin
						cnt <= '0;
						state <= link_idle;
					end else begin
						cnt <= cnt + 5'h01;
					end
				end
			endcase
		end
	end

	// Output bit, changed only on the rising edge
	always_ff @(posedge link.sclk) begin
		if (!link_rst_b || reset_seen) begin
			dout_link <= 1'b0;
			shreg <= '0;
		end else if (stop_last && code_conv) begin
			dout_link <= 1'b1;
		end else if (state == link_ack && cnt == `ACK_LAST) begin
			dout_link <= 1'b0;
		end else if (state == link_read) begin
			if (cnt == '0) begin
				{dout_link, shreg} <= {rd_word, 1'b0};
			end else if (cnt == `READ_LAST) begin
				dout_link <= 1'b0;
			end else begin
				{dout_link, shreg} <= {shreg, 1'b0};
			end
		end
	end

	// Events toward the converter domain, as toggles
	always_ff @(posedge link.sclk) begin
		if (!link_rst_b) begin
			req_tgl <= 1'b0;
			kind_link <= 1'b0;
			abort_tgl <= 1'b0;
		end else begin
			if (reset_seen) begin
				abort_tgl <= ~abort_tgl;
			end else if (stop_last && code_conv) begin
				req_tgl <= ~req_tgl;
				kind_link <= (setup == CODE_TEMPERATURE);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			req_sync <= '0;
			kind_sync <= '0;
			abort_sync <= '0;
		end else begin
			req_sync <= {req_sync[1:0], req_tgl};
			kind_sync <= {kind_sync[0], kind_link};
			abort_sync <= {abort_sync[1:0], abort_tgl};
		end
	end

	assign req_edge = req_sync[2] ^ req_sync[1];
	assign abort_edge = abort_sync[2] ^ abort_sync[1];

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else if (req_edge) begin
			busy <= 1'b1;
		end else if (abort_edge || adc_done) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			adc_start <= 1'b0;
			adc_kind <= 1'b0;
			adc_abort <= 1'b0;
		end else begin
			adc_start <= req_edge;
			adc_abort <= abort_edge && busy && !req_edge;
			if (req_edge) begin
				adc_kind <= kind_sync[1];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			result <= '0;
		end else if (busy && adc_done && !req_edge && !abort_edge) begin
			result <= adc_value;
		end
	end
endmodule

// ===== test/sensor_port_assertions.sv
`timescale 1ns/10ps
module sensor_port_assertions #(
	parameter int HALF = 4
)(
	// Host clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Link wires
	input wire logic sclk,
	input wire logic din,
	input wire logic dout
);
	logic [7:0] hi_cnt;
	logic [7:0] quiet;
	logic [4:0] rd_cnt;
	logic rd_on;
	// Longer than any low phase inside a readout, shorter than the gap
	localparam logic [7:0] GAP = 8'(HALF + 1);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge core_clk) begin
		if (!rst_b || !sclk) hi_cnt <= 8'h00;
		else hi_cnt <= hi_cnt + 8'h01;
	end
	// Cycles since the link clock was last high, saturating
	always_ff @(posedge core_clk) begin
		if (!rst_b || sclk) quiet <= 8'h00;
		else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
	end
	// Rises counted from the end of a conversion until the link goes quiet
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rd_on <= 1'b0;
			rd_cnt <= 5'h00;
		end else if ($fell(dout) && !sclk && !$past(sclk)) begin
			rd_on <= 1'b1;
			rd_cnt <= 5'h00;
		end else if (rd_on && quiet == GAP) begin
			rd_on <= 1'b0;
		end else if (rd_on && $rose(sclk)) begin
			rd_cnt <= rd_cnt + 5'h01;
		end
	end
	property p_rise_at_sclk;
		$rose(dout) |-> $rose(sclk);
	endproperty
	a_rise_at_sclk: assert property (p_rise_at_sclk)
		else $error("output rose away from a link clock rise");
	property p_hold_high;
		sclk && !$rose(sclk) |-> $stable(dout);
	endproperty
	a_hold_high: assert property (p_hold_high)
		else $error("output moved while link clock high");
	property p_fall_edge;
		$fell(sclk) && $past(rst_b) |-> $stable(dout);
	endproperty
	a_fall_edge: assert property (p_fall_edge)
		else $error("output moved at link clock fall");
	property p_din_on_low;
		$changed(din) |-> !sclk;
	endproperty
	a_din_on_low: assert property (p_din_on_low)
		else $error("input bit moved while link clock high");
	property p_half;
		$fell(sclk) && $past(rst_b) |-> hi_cnt == 8'(HALF);
	endproperty
	a_half: assert property (p_half)
		else $error("link clock high phase has wrong length");
	property p_read_go;
		$fell(dout) && !sclk && !$past(sclk) |-> ##[1:20] $rose(sclk);
	endproperty
	a_read_go: assert property (p_read_go)
		else $error("readout did not start after conversion end");
	property p_read_len;
		rd_on && quiet == GAP |-> rd_cnt == 5'h11;
	endproperty
	a_read_len: assert property (p_read_len)
		else $error("readout clock count wrong");
	property p_idle_low;
		rd_on && quiet == GAP |-> !dout;
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("output not low after readout");
	c_eoc: cover property ($fell(dout) && !sclk);
	c_read_done: cover property (rd_on && quiet == GAP);
	c_ack: cover property ($rose(dout));
endmodule

// ===== test/pressure_sensor_serial_port_test.sv
`timescale 1ns/10ps
`include "sensor_consts.svh"
module pressure_sensor_serial_port_test;
	import sensor_pkg::*;
	localparam logic [63:0] CAL = 64'hA5C31E780FF09B26;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_valid = 1'b0;
	cmd_e cmd_op = cmd_reset;
	logic cmd_ready, rsp_valid, adc_start, adc_kind, adc_abort;
	logic [15:0] rsp_data;
	logic adc_done = 1'b0;
	logic [15:0] adc_value = 16'h0000;
	logic [20:0] ish, rfrm;
	logic [16:0] osh;
	logic [9:0] frm;
	logic ack;
	logic [3:0] code [6];
	int rises, falls, starts, err_total, total_checks;
	sensor_link_if link();
	sensor_port_host #(.SCLK_HALF(`SCLK_HALF)) sensor_port_host_inst (
		.core_clk(core_clk), .rst_b(rst_b), .link(link.host),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	sensor_port_dev #(.CALIB_STORE(CAL)) sensor_port_dev_inst (
		.core_clk(core_clk), .rst_b(rst_b), .link(link.dev),
		.adc_start(adc_start), .adc_kind(adc_kind), .adc_abort(adc_abort),
		.adc_done(adc_done), .adc_value(adc_value));
	sensor_port_assertions #(.HALF(int'(`SCLK_HALF)))
		sensor_port_assertions_inst (.core_clk(core_clk), .rst_b(rst_b),
		.sclk(link.sclk), .din(link.din), .dout(link.dout));
	always #20 core_clk = ~core_clk;
	// Host-side view of the wire: bits in on rises, bits out on falls
	always @(posedge link.sclk) begin
		ish = {ish[19:0], link.din};
		rises = rises + 1;
		if (rises == 10) frm = ish[9:0];
		if (rises == 21) rfrm = ish;
	end
	always @(negedge link.sclk) begin
		osh = {osh[15:0], link.dout};
		falls = falls + 1;
		if (falls == 10) ack = link.dout;
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	// Converter stand-in: answers every start after a fixed delay
	initial forever begin
		@(posedge core_clk);
		#2;
		if (adc_start === 1'b1) begin
			starts++;
			chk("kind", cmd_op == cmd_temperature, adc_kind);
			repeat (80) @(posedge core_clk);
			#1 adc_done = 1'b1;
			@(posedge core_clk);
			#1 adc_done = 1'b0;
		end
	end
	task automatic do_cmd(input cmd_e op, input logic [15:0] w);
		logic got;
		int n, st;
		got = 1'b0;
		st = starts;
		for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) tick();
		rises = 0;
		falls = 0;
		cmd_op = op;
		cmd_valid = 1'b1;
		tick();
		cmd_valid = 1'b0;
		for (n = 0; n < 3000 && cmd_ready !== 1'b1; n++) begin
			tick();
			if (rsp_valid === 1'b1) got = 1'b1;
		end
		if (n == 3000) begin
			chk("timeout", 0, 1);
			close_out();
		end
		if (op == cmd_reset) begin
			chk("reset_bits", `RESET_PATTERN, rfrm);
			chk("rises", 21, rises);
		end else begin
			chk("frame", {3'h7, code[op], 3'h0}, frm);
			chk("ack", op < 2, ack);
			chk("rises", op < 2 ? 29 : 27, rises);
			chk("wire_word", {w, 1'b0}, osh);
			chk("rsp", w, rsp_data);
		end
		chk("rsp_seen", op != cmd_reset, got);
		chk("starts", st + (op < 2), starts);
		chk("dout_idle", 0, link.dout);
	endtask
	initial begin
		code = '{`CODE_PRESSURE, `CODE_TEMPERATURE, `CODE_CALIB_FIRST,
			`CODE_CALIB_SECOND, `CODE_CALIB_THIRD, `CODE_CALIB_FOURTH};
		repeat (16) tick();
		rst_b = 1'b1;
		tick();
		do_cmd(cmd_reset, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			do_cmd(cmd_e'(i + 2), CAL[63 - 16 * i -: 16]);
		end
		adc_value = 16'hB38D;
		do_cmd(cmd_pressure, 16'hB38D);
		adc_value = 16'h4C72;
		do_cmd(cmd_temperature, 16'h4C72);
		do_cmd(cmd_reset, 16'h0000);
		adc_value = 16'h8001;
		do_cmd(cmd_pressure, 16'h8001);
		do_cmd(cmd_calib_fourth, CAL[15:0]);
		close_out();
	end
endmodule
